// File: pkg/charger_cfg_pkg.sv
// Purpose: constants shared by the charger configuration bank
// Assumes: 8-bit command codes, 16-bit register data words
// Notes:   values after reset and counts of cycles live here
`default_nettype none
package charger_cfg_pkg;
    // =========================================================
    // register command codes
    localparam logic [7:0] ADDR_SYSTEM_CONFIG  = 8'h14;
    localparam logic [7:0] ADDR_INPUT_CUR_CAP  = 8'h15;
    localparam logic [7:0] ADDR_INPUT_V_FLOOR  = 8'h16;
    localparam logic [7:0] ADDR_STORAGE_ARM    = 8'h19;
    localparam logic [7:0] ADDR_CHARGE_CUR     = 8'h1A;
    localparam logic [7:0] ADDR_CHARGE_VOLT    = 8'h1B;
    localparam logic [7:0] ADDR_TAPER_THRESH   = 8'h1C;
    // =========================================================
    // field widths
    localparam int SYSCFG_W = 6;
    localparam int CUR_CAP_W = 6;
    localparam int V_FLOOR_W = 8;
    localparam int CHG_CUR_W = 5;
    localparam int CHG_VOLT_W = 6;
    // =========================================================
    // system configuration bit positions
    localparam int BIT_EQUALIZE_REQ  = 0;
    localparam int BIT_TRACK_EN      = 1;
    localparam int BIT_TELEM_ALWAYS  = 2;
    localparam int BIT_TELEM_FAST    = 3;
    localparam int BIT_RES_MEAS_REQ  = 4;
    localparam int BIT_HALT_CHARGE   = 5;
    // =========================================================
    // values after reset
    localparam logic [5:0]  RST_SYSCFG      = 6'h00;
    localparam logic [5:0]  RST_CUR_CAP     = 6'h3F;
    localparam logic [7:0]  RST_V_FLOOR     = 8'h1F;
    localparam logic [15:0] RST_STORAGE_ARM = 16'h0000;
    localparam logic [4:0]  RST_CHG_CUR     = 5'h1F;
    localparam logic [5:0]  RST_CHG_VOLT    = 6'h15;
    localparam logic [15:0] RST_TAPER       = 16'h0888;
    localparam logic [15:0] STORAGE_ARM_KEY = 16'h534D;
    // =========================================================
    // telemetry timing at 200 MHz
    localparam longint CLK_HZ        = 200000000;
    localparam longint TEL_FAST_MS   = 11;
    localparam longint TEL_SLOW_S    = 5;
    localparam longint TEL_FAST_CYC  = CLK_HZ * TEL_FAST_MS / 1000;
    localparam longint TEL_SLOW_CYC  = CLK_HZ * TEL_SLOW_S;
endpackage
`default_nettype wire

// File: rtl/telemetry_pacer.sv
// Purpose: periodic measurement trigger
// Assumes: period inputs are constant while enabled
// Notes:   pulse is one clock wide
`default_nettype none
module telemetry_pacer #(
    parameter int CNT_W = 32
) (
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic             run_i,
    input  wire logic [CNT_W-1:0] period_i,
    output logic                  tick_o
);
    logic [CNT_W-1:0] count;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else if (count >= period_i - CNT_W'(1)) begin
            count  <= '0;
            tick_o <= 1'b1;
        end else begin
            count  <= count + CNT_W'(1);
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: rtl/charger_config_settings_bank.sv
// Purpose: configuration register slice of a lead-acid charger
// Assumes: host bridge delivers one-cycle write/read strobes
// Notes:   analog loops sit outside; dac values are driven out
//
// Function
// - resistance request starts measure at charge start, or now if charging
// - fast rate bit gives 11ms telemetry; else 5s when not charging
// - always-on bit keeps telemetry running even on battery alone
// - tracking enable lets tracking drive the undervoltage dac
// - equalize request runs or queues equalize after absorb ends
// - equalize request self-clears on timeout, halt, or power cycle
// - host writing zero to equalize request cancels pending or running
// - input current cap 6 bits at 0x15, reset 63
// - input voltage floor 8 bits at 0x16, reset 31
// - tracking result overrides floor at the dac; reads return the floor
// - writing key to arm register arms ship mode, effective below 1V
// - charge current target 5 bits at 0x1A, reset 31
// - current dac follows target unless thermal regulation reduces it
// - charge voltage target 6 bits at 0x1B, reset 21
// - voltage dac follows target unless temperature compensation alters
// - signed taper threshold at 0x1C, reset 2184, ends absorb
// - config bit 5 halts charging while set
`default_nettype none
module charger_config_settings_bank
    import charger_cfg_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // register access from the serial bridge
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wr_data_i,
    output logic      [15:0] rd_data_o,
    output logic             rd_valid_o,
    // charge state machine context
    input  wire logic        charging_i,
    input  wire logic        charge_start_i,
    input  wire logic        in_absorb_i,
    input  wire logic        absorb_timeout_i,
    input  wire logic        equalize_timeout_i,
    input  wire logic signed [15:0] battery_current_i,
    input  wire logic        input_power_i,
    input  wire logic        vin_below_1v_i,
    input  wire logic        thermal_reg_i,
    input  wire logic [4:0]  thermal_limit_i,
    input  wire logic        temp_comp_en_i,
    input  wire logic [5:0]  temp_comp_volt_i,
    input  wire logic [7:0]  tracking_floor_i,
    // controls toward the charger
    output logic             halt_charge_o,
    output logic             res_measure_o,
    output logic             telemetry_tick_o,
    output logic             equalize_run_o,
    output logic             absorb_done_o,
    output logic             ship_mode_o,
    output logic      [5:0]  current_cap_dac_o,
    output logic      [7:0]  undervolt_dac_o,
    output logic      [4:0]  charge_cur_dac_o,
    output logic      [5:0]  charge_volt_dac_o
);
    // =========================================================
    // pin synchronisers for slow external levels
    logic vin_low_s1;
    logic vin_low;
    logic pwr_s1;
    logic pwr;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vin_low_s1 <= 1'b0;
            vin_low    <= 1'b0;
            pwr_s1     <= 1'b0;
            pwr        <= 1'b0;
        end else begin
            vin_low_s1 <= vin_below_1v_i;
            vin_low    <= vin_low_s1;
            pwr_s1     <= input_power_i;
            pwr        <= pwr_s1;
        end
    end

    // =========================================================
    // register storage
    logic [5:0]  sys_cfg;
    logic [5:0]  input_current_cap;
    logic [7:0]  input_voltage_floor;
    logic [15:0] storage_mode_arm;
    logic [4:0]  charge_current_target;
    logic [5:0]  charge_voltage_target;
    logic signed [15:0] taper_current_threshold;
    logic        wr_cfg;
    logic        taper_hit;
    logic        absorb_end;

    typedef enum logic [1:0] {
        EQ_IDLE    = 2'b00,
        EQ_QUEUED  = 2'b01,
        EQ_RUNNING = 2'b10
    } eq_state_t;

    logic [SYSCFG_W-1:1] cfg_upper;
    logic                eq_req;
    logic                eq_cancel;
    eq_state_t           eq_state;

    assign sys_cfg    = {cfg_upper, eq_req};
    assign wr_cfg     = wr_en_i && (addr_i == ADDR_SYSTEM_CONFIG);
    // absorb ends on its timer or on battery current under threshold
    assign taper_hit  = battery_current_i < taper_current_threshold;
    assign absorb_end = in_absorb_i && (absorb_timeout_i || taper_hit);

    // plain bits of the system configuration register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_upper <= RST_SYSCFG[SYSCFG_W-1:1];
        end else if (wr_cfg) begin
            cfg_upper <= wr_data_i[SYSCFG_W-1:1];
        end
    end

    // equalize request: host set/clear, self clear on end or halt
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eq_req <= 1'b0;
        end else if (wr_cfg) begin
            eq_req <= wr_data_i[BIT_EQUALIZE_REQ];
        end else if ((equalize_run_o && equalize_timeout_i)
                     || sys_cfg[BIT_HALT_CHARGE]) begin
            eq_req <= 1'b0;
        end
    end

    // equalize phase: queued on request, started when absorb ends
    // a cleared request, or a host write of zero, drops any phase
    assign eq_cancel = !eq_req
                       || (wr_cfg && !wr_data_i[BIT_EQUALIZE_REQ]);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            absorb_done_o <= 1'b0;
        end else begin
            absorb_done_o <= absorb_end;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eq_state       <= EQ_IDLE;
            equalize_run_o <= 1'b0;
        end else if (eq_cancel) begin
            eq_state       <= EQ_IDLE;
            equalize_run_o <= 1'b0;
        end else begin
            case (eq_state)
                EQ_IDLE, EQ_QUEUED: begin
                    if (absorb_end) begin
                        eq_state       <= EQ_RUNNING;
                        equalize_run_o <= 1'b1;
                    end else begin
                        eq_state       <= EQ_QUEUED;
                        equalize_run_o <= 1'b0;
                    end
                end
                EQ_RUNNING: begin
                    if (equalize_timeout_i) begin
                        eq_state       <= EQ_IDLE;
                        equalize_run_o <= 1'b0;
                    end
                end
                default: begin
                    eq_state       <= EQ_IDLE;
                    equalize_run_o <= 1'b0;
                end
            endcase
        end
    end

    // value registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            input_current_cap       <= RST_CUR_CAP;
            input_voltage_floor     <= RST_V_FLOOR;
            storage_mode_arm        <= RST_STORAGE_ARM;
            charge_current_target   <= RST_CHG_CUR;
            charge_voltage_target   <= RST_CHG_VOLT;
            taper_current_threshold <= RST_TAPER;
        end else if (wr_en_i) begin
            case (addr_i)
                ADDR_INPUT_CUR_CAP:
                    input_current_cap <= wr_data_i[CUR_CAP_W-1:0];
                ADDR_INPUT_V_FLOOR:
                    input_voltage_floor <= wr_data_i[V_FLOOR_W-1:0];
                ADDR_STORAGE_ARM:
                    storage_mode_arm <= wr_data_i;
                ADDR_CHARGE_CUR:
                    charge_current_target <= wr_data_i[CHG_CUR_W-1:0];
                ADDR_CHARGE_VOLT:
                    charge_voltage_target <= wr_data_i[CHG_VOLT_W-1:0];
                ADDR_TAPER_THRESH:
                    taper_current_threshold <= wr_data_i;
                default: begin
                end
            endcase
        end
    end

    // =========================================================
    // read back, narrow fields zero-extended
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o  <= 16'h0000;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_en_i;
            if (rd_en_i) begin
                case (addr_i)
                    ADDR_SYSTEM_CONFIG:
                        rd_data_o <= {10'h000, sys_cfg};
                    ADDR_INPUT_CUR_CAP:
                        rd_data_o <= {10'h000, input_current_cap};
                    ADDR_INPUT_V_FLOOR:
                        rd_data_o <= {8'h00, input_voltage_floor};
                    ADDR_STORAGE_ARM:
                        rd_data_o <= storage_mode_arm;
                    ADDR_CHARGE_CUR:
                        rd_data_o <= {11'h000, charge_current_target};
                    ADDR_CHARGE_VOLT:
                        rd_data_o <= {10'h000, charge_voltage_target};
                    ADDR_TAPER_THRESH:
                        rd_data_o <= taper_current_threshold;
                    default:
                        rd_data_o <= 16'h0000;
                endcase
            end
        end
    end

    // =========================================================
    // control outputs and active dac values
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            halt_charge_o     <= 1'b0;
            ship_mode_o       <= 1'b0;
            current_cap_dac_o <= RST_CUR_CAP;
            undervolt_dac_o   <= RST_V_FLOOR;
            charge_cur_dac_o  <= RST_CHG_CUR;
            charge_volt_dac_o <= RST_CHG_VOLT;
        end else begin
            halt_charge_o <= sys_cfg[BIT_HALT_CHARGE];
            ship_mode_o   <= (storage_mode_arm == STORAGE_ARM_KEY)
                             && vin_low;
            current_cap_dac_o <= input_current_cap;
            if (sys_cfg[BIT_TRACK_EN])
                undervolt_dac_o <= tracking_floor_i;
            else
                undervolt_dac_o <= input_voltage_floor;
            if (thermal_reg_i && thermal_limit_i < charge_current_target)
                charge_cur_dac_o <= thermal_limit_i;
            else
                charge_cur_dac_o <= charge_current_target;
            if (temp_comp_en_i)
                charge_volt_dac_o <= temp_comp_volt_i;
            else
                charge_volt_dac_o <= charge_voltage_target;
        end
    end

    // =========================================================
    // battery resistance measurement trigger, then self clear
    logic res_armed;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_armed     <= 1'b0;
            res_measure_o <= 1'b0;
        end else begin
            res_measure_o <= 1'b0;
            if (wr_cfg && wr_data_i[BIT_RES_MEAS_REQ])
                res_armed <= 1'b1;
            else if (res_armed && (charging_i || charge_start_i)) begin
                res_armed     <= 1'b0;
                res_measure_o <= 1'b1;
            end
        end
    end

    // =========================================================
    // telemetry pacing
    logic        tel_run;
    logic        tel_fast;
    logic [31:0] tel_period;

    // on with input power, or always when forced on
    assign tel_run = pwr || sys_cfg[BIT_TELEM_ALWAYS];
    assign tel_fast = sys_cfg[BIT_TELEM_FAST] || charging_i;
    assign tel_period = tel_fast ? 32'(TEL_FAST_CYC)
                                 : 32'(TEL_SLOW_CYC);

    telemetry_pacer #(
        .CNT_W (32)
    ) u_pacer (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .run_i    (tel_run),
        .period_i (tel_period),
        .tick_o   (telemetry_tick_o)
    );
endmodule
`default_nettype wire

// File: tb/reg_host.sv
// Purpose: host model that issues register accesses to the bank
// Assumes: one-cycle strobes, read answer one cycle after the strobe
// Notes:   a released bus shows the inverse of its last value
`default_nettype none
module reg_host (
    input  wire logic        clock_i,
    input  wire logic [15:0] rd_data_i,
    input  wire logic        rd_valid_i,
    output var  logic        wr_en_o,
    output var  logic        rd_en_o,
    output var  logic [7:0]  addr_o,
    output var  logic [15:0] wr_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_en_o, rd_en_o, addr_o, wr_data_o} = '0;
    // ==========================================================
    // accesses; a zero to the equalize bit may go out at any time
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clock_i);
        addr_o = a;
        wr_data_o = d;
        wr_en_o = 1'b1;
        @(negedge clock_i);
        wr_en_o = 1'b0;
        addr_o = ~a;
        wr_data_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clock_i);
        addr_o = a;
        rd_en_o = 1'b1;
        @(negedge clock_i);
        rd_en_o = 1'b0;
        addr_o = ~a;
        d = rd_valid_i ? rd_data_i : 16'hDEAD;
    endtask
endmodule
`default_nettype wire

// File: tb/charger_cfg_checker.sv
// Purpose: port-level checks of the charger configuration bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound into every instance of the bank
`default_nettype none
module charger_cfg_checker
    import charger_cfg_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        wr_en_i,
    input wire logic        rd_en_i,
    input wire logic [7:0]  addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic [15:0] rd_data_o,
    input wire logic        rd_valid_o,
    input wire logic        equalize_timeout_i,
    input wire logic        vin_below_1v_i,
    input wire logic        thermal_reg_i,
    input wire logic [4:0]  thermal_limit_i,
    input wire logic        halt_charge_o,
    input wire logic        equalize_run_o,
    input wire logic        ship_mode_o,
    input wire logic [5:0]  current_cap_dac_o,
    input wire logic [4:0]  charge_cur_dac_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] cap_q1;
    logic [5:0] cap_q2;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // write data history for the dac comparison
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {cap_q2, cap_q1} <= '0;
        end else begin
            {cap_q2, cap_q1} <= {cap_q1, wr_data_i[5:0]};
        end
    end
    // ==========================================================
    // properties
    a_read_answer: assert property (rd_en_i |=> rd_valid_o)
        else $error("read without answer");
    a_no_stray_valid: assert property (!rd_en_i |=> !rd_valid_o)
        else $error("read valid without read");
    a_unmapped_zero: assert property
        (rd_en_i && addr_i == 8'h17 |=> rd_data_o == 16'h0000)
        else $error("unmapped read not zero");
    a_cap_follows: assert property
        (wr_en_i && addr_i == ADDR_INPUT_CUR_CAP |=> ##1
         current_cap_dac_o == cap_q2)
        else $error("current cap dac did not take write");
    a_thermal_caps: assert property
        ((thermal_reg_i && $stable(thermal_limit_i)) [*3] |->
         charge_cur_dac_o <= thermal_limit_i)
        else $error("charge current dac above thermal limit");
    a_halt_stops_eq: assert property
        (halt_charge_o [*2] |-> !equalize_run_o)
        else $error("equalize runs while halted");
    a_eq_timeout: assert property
        (equalize_run_o && equalize_timeout_i |=> !equalize_run_o)
        else $error("equalize survived its timeout");
    a_ship_needs_low: assert property
        (!vin_below_1v_i [*5] |-> !ship_mode_o)
        else $error("ship mode with input present");
endmodule
bind charger_config_settings_bank charger_cfg_checker chk_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .equalize_timeout_i(equalize_timeout_i),
    .vin_below_1v_i(vin_below_1v_i), .thermal_reg_i(thermal_reg_i),
    .thermal_limit_i(thermal_limit_i), .halt_charge_o(halt_charge_o),
    .equalize_run_o(equalize_run_o), .ship_mode_o(ship_mode_o),
    .current_cap_dac_o(current_cap_dac_o),
    .charge_cur_dac_o(charge_cur_dac_o));
`default_nettype wire

// File: tb/charger_config_settings_bank_tb.sv
// Purpose: self-checking bench for the charger configuration bank
// Assumes: inputs change on falling edges
// Notes:   telemetry periods are too long to run here
`default_nettype none
module charger_config_settings_bank_tb;
    import charger_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] AD [7] = '{8'h14, 8'h15, 8'h16, 8'h19,
                                      8'h1A, 8'h1B, 8'h1C};
    localparam logic [15:0] RV [7] = '{16'h0, 16'h3F, 16'h1F, 16'h0,
                                       16'h1F, 16'h15, 16'h888};
    localparam logic [15:0] MK [7] = '{16'h3F, 16'h3F, 16'hFF, 16'hFFFF,
                                       16'h1F, 16'h3F, 16'hFFFF};
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        wr, rd, vld, halt, res, tick, eq, done, ship;
    logic [7:0]  ad, uv;
    logic [15:0] wd, rdat, w;
    logic        chg = 0, cst = 0, abs = 0, ato = 0, eto = 0, vlow = 0;
    logic        thr = 0, cen = 0, pin_pwr = 1;
    logic [4:0]  tlim = 0, cur;
    logic [5:0]  cv = 0, cap, vlt;
    logic [7:0]  trk = 0;
    logic signed [15:0] ibat = 16'sh1000;
    int          mismatches = 0, checked = 0, res_n = 0;
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) if (res === 1'b1) res_n++;
    charger_config_settings_bank dut_u (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .wr_en_i(wr), .rd_en_i(rd), .addr_i(ad),
        .wr_data_i(wd), .rd_data_o(rdat), .rd_valid_o(vld),
        .charging_i(chg), .charge_start_i(cst), .in_absorb_i(abs),
        .absorb_timeout_i(ato), .equalize_timeout_i(eto),
        .battery_current_i(ibat), .input_power_i(pin_pwr),
        .vin_below_1v_i(vlow), .thermal_reg_i(thr), .thermal_limit_i(tlim),
        .temp_comp_en_i(cen), .temp_comp_volt_i(cv), .tracking_floor_i(trk),
        .halt_charge_o(halt), .res_measure_o(res), .telemetry_tick_o(tick),
        .equalize_run_o(eq), .absorb_done_o(done), .ship_mode_o(ship),
        .current_cap_dac_o(cap), .undervolt_dac_o(uv),
        .charge_cur_dac_o(cur), .charge_volt_dac_o(vlt));
    reg_host host_u (.clock_i(clock_i), .rd_data_i(rdat), .rd_valid_i(vld),
        .wr_en_o(wr), .rd_en_o(rd), .addr_o(ad), .wr_data_o(wd));
    // ==========================================================
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic give_verdict();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ==========================================================
    // watchdog: the tests need under two hundred cycles
    initial begin
        #100us;
        mismatches++;
        give_verdict();
    end
    // ==========================================================
    // tests
    initial begin
        idle(10);
        rst_n_i = 1'b1;
        for (int i = 0; i < 7; i++) begin
            host_u.rd(AD[i], w);
            check(w, RV[i]);
        end
        check({2'h0, cap, uv}, 16'h3F1F);
        check({5'h0, cur, vlt}, {5'h0, 5'h1F, 6'h15});
        for (int i = 1; i < 7; i++) begin
            host_u.wr(AD[i], 16'hFFEA);
            host_u.rd(AD[i], w);
            check(w, 16'hFFEA & MK[i]);
        end
        check({2'h0, cap, uv}, 16'h2AEA);
        check({5'h0, cur, vlt}, {5'h0, 5'h0A, 6'h2A});
        for (int i = 1; i < 7; i++) host_u.wr(AD[i], RV[i]);
        host_u.wr(8'h17, 16'hFFFF);
        host_u.rd(8'h17, w);
        check(w, 16'h0000);
        host_u.wr(AD[0], 16'h0021);
        idle(4);
        check({halt, eq}, 2'b10);
        host_u.rd(AD[0], w);
        check(w, 16'h0020);
        trk = 8'h5C;
        host_u.wr(AD[0], 16'h0002);
        idle(3);
        check(uv, 8'h5C);
        host_u.wr(AD[0], 16'h0000);
        idle(3);
        check(uv, 8'h1F);
        abs = 1;
        ibat = 16'sh0888;
        host_u.wr(AD[0], 16'h0001);
        idle(4);
        check({done, eq}, 2'b00);
        ato = 1;
        idle(3);
        check({done, eq}, 2'b11);
        {ato, abs, eto} = 3'b001;
        idle(1);
        eto = 0;
        idle(2);
        host_u.rd(AD[0], w);
        check({w[0], eq}, 2'b00);
        abs = 1;
        ibat = 16'sh0887;
        host_u.wr(AD[0], 16'h0001);
        idle(3);
        check(eq, 1'b1);
        abs = 0;
        host_u.wr(AD[0], 16'h0000);
        idle(2);
        check(eq, 1'b0);
        abs = 1;
        host_u.wr(AD[0], 16'h0001);
        idle(3);
        check(eq, 1'b1);
        host_u.wr(AD[0], 16'h0021);
        idle(4);
        host_u.rd(AD[0], w);
        check({w[0], halt, eq}, 3'b010);
        abs = 0;
        host_u.wr(AD[0], 16'h0000);
        idle(2);
        host_u.wr(AD[3], 16'h534D);
        idle(6);
        check(ship, 1'b0);
        vlow = 1;
        idle(6);
        check(ship, 1'b1);
        host_u.wr(AD[3], 16'h534C);
        idle(6);
        check(ship, 1'b0);
        vlow = 0;
        host_u.wr(AD[0], 16'h0010);
        idle(4);
        check(16'(res_n), 16'h0);
        cst = 1;
        idle(1);
        cst = 0;
        idle(4);
        check(16'(res_n), 16'h1);
        chg = 1;
        host_u.wr(AD[0], 16'h0010);
        idle(4);
        check(16'(res_n), 16'h2);
        {tlim, thr, cv, cen} = {5'h03, 1'b1, 6'h30, 1'b1};
        idle(5);
        check({cur, vlt}, {5'h03, 6'h30});
        {thr, cen} = 2'b00;
        idle(5);
        check({cur, vlt}, {5'h1F, 6'h15});
        check(tick, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
